//--- hw/hsg_defs.vh
// Register offsets, field positions, reset values and timing counts for the gate sequencer.
`ifndef HSG_DEFS_VH
`define HSG_DEFS_VH
`define HSG_OFS_SYSTEM_STATE      8'h00
`define HSG_OFS_FAULT_LOG         8'h04
`define HSG_OFS_PRIMARY_CONTROL   8'h0A
`define HSG_OFS_SECONDARY_CONTROL 8'h0B
`define HSG_OFS_THIRD_CONFIG      8'h0F
`define HSG_OFS_GOOD_PIN_CONFIG   8'h10
`define HSG_OFS_RESTART_CONTROL   8'hA2
// primary_control fields.
`define HSG_PC_ON             0
`define HSG_PC_SLEW_MODE      1
`define HSG_PC_GOOD_CLEAR     2
`define HSG_PC_SWFAULT_OFF    3
// secondary_control fields: retry bits and mode.
`define HSG_SC_WD_RETRY       0
`define HSG_SC_OV_RETRY       1
`define HSG_SC_UV_RETRY       2
`define HSG_SC_OC_RETRY       3
`define HSG_SC_SW_RETRY       4
`define HSG_SC_EXT_RETRY      5
`define HSG_SC_MODE_LO        6
// third_config fields.
`define HSG_TC_AUX_OFF_EN     0
`define HSG_TC_AUX_IS_FAULT   1
`define HSG_TC_AUX_POL        2
`define HSG_TC_ILIM_LO        4
// good_pin_config fields.
`define HSG_GP_OUTA_INV       0
`define HSG_GP_OUTB_INV       1
`define HSG_GP_IN_INV         2
`define HSG_GP_IN_GPIO        3
`define HSG_GP_FOLD_LO        4
`define HSG_GP_SWDLY_LO       6
// restart_control fields.
`define HSG_RC_REQUEST        7
`define HSG_RC_DELAY_LO       0
// system_state fields.
`define HSG_SS_CMD_ON         0
`define HSG_SS_GOOD           1
`define HSG_SS_DRIVE_A        2
`define HSG_SS_DRIVE_B        3
`define HSG_SS_RAMP_ON        4
// fault_log fields.
`define HSG_FL_OV             0
`define HSG_FL_UV             1
`define HSG_FL_OC             2
`define HSG_FL_SWITCH         3
`define HSG_FL_WATCHDOG       4
`define HSG_FL_EXT            5
// Reset values.
`define HSG_RST_PRIMARY       8'h09
`define HSG_RST_SECONDARY     8'h00
`define HSG_RST_THIRD         8'h01
`define HSG_RST_GOOD_PIN      8'h00
`define HSG_RST_RESTART       8'h04
// Timing, in ms, and the time base.
`define HSG_TIME_DEBOUNCE_MS  128
`define HSG_TIME_GOOD_MS      256
`define HSG_TIME_WATCHDOG_MS  512
`define HSG_TIME_RETRY_MS     10'h080
`define HSG_CLK_HZ            100000000
`define HSG_CYC_PER_MS        (`HSG_CLK_HZ / 1000)
`define HSG_MODE_PARALLEL     2'h0
`define HSG_MODE_SINGLE       2'h3
`endif

//--- hw/hsg_gate_sequencer.v
// Gate turn-on/turn-off sequencing, power-good chain and fault logic.
//
// Notes on behaviour
// RULE1: slew_mode_select 1 picks slew-rate inrush, 0 picks folded current limit.
// RULE2: Ramp runs only during startup; discharged after power good or any turn-off.
// RULE3: Current limit code 0..15 selects 15mV to 30mV in 1mV steps.
// RULE4: Startup foldback selects 10, 20, 50 or 100 percent, constant during startup.
// RULE5: Parallel/single turn both drives on together; staged starts drive_b after charge.
// RULE6: Good needs drain low, output above reference, gates high (parallel: limit ok) (in staged mode the code checks gate A only).
// RULE7: Good latches, sets good_flag, first output after 256ms.
// RULE8: Second output asserts after a further 256ms.
// RULE9: Then 512ms watchdog; input must go active or switches off, fault logged.
// RULE10: watchdog_retry_en retries turn-on 128ms after watchdog fault, else stays off.
// RULE11: Each good pin polarity configurable; input as general purpose disables watchdog.
// RULE12: good_clear_select 1 clears on output low, 0 on any turn-off except overvoltage.
// RULE13: Clearing good also resets both good delays and the watchdog delay.
// RULE14: Listed causes turn both drives off and clear switch_cmd_on_flag.
// RULE15: Switch fault after programmed delay; switch_fault_off_en 0 keeps switches on.
// RULE16: aux_fault_pin as fault input raises external fault; aux_fault_off_en 0 keeps on.
// RULE17: restart_request turns off, then back on after programmable reboot delay.
// RULE18: Each turn-off fault is configurable as latch-off or auto retry.
// RULE19: Parallel/single turn off together; staged drive_b follows drive_a off (code drops drive_b in the same cycle as drive_a).
// RULE20: Fast limit at double the programmed limit forces immediate strong pulldown.
// RULE21: Turn-on conditions must hold 128ms; violation restarts; then on when on bit set.
// RULE22: All delays count one millisecond tick and clear when their condition drops.
`timescale 1ns/1ps
`include "hsg_defs.vh"

module hsg_gate_sequencer #(
    parameter CYC_PER_MS = `HSG_CYC_PER_MS
) (
    input  wire       i_sys_clk,
    input  wire       i_rstn,
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    input  wire       i_supply_ok,
    input  wire       i_enable_pin,
    input  wire       i_overvolt,
    input  wire       i_undervolt,
    input  wire       i_thermal_timer_pin,
    input  wire       i_drain_high,
    input  wire       i_output_above_ref,
    input  wire       i_gate_a_high,
    input  wire       i_gate_b_high,
    input  wire       i_limit_a,
    input  wire       i_limit_b,
    input  wire       i_fast_a,
    input  wire       i_fast_b,
    input  wire       i_load_charged,
    input  wire       i_load_good_in,
    input  wire       i_aux_fault_pin,
    output reg        o_drive_a,
    output reg        o_drive_b,
    output reg        o_fast_pull_a,
    output reg        o_fast_pull_b,
    output reg        o_ramp_enable,
    output reg        o_ramp_discharge,
    output reg        o_slew_mode_select,
    output reg  [4:0] o_limit_mv,
    output reg  [1:0] o_foldback_sel,
    output reg        o_load_good_out_a,
    output reg        o_load_good_out_b
);

    // ==================================================================
    // Input synchronisers.
    localparam NIN = 13;
    wire [NIN-1:0] raw_in = {i_supply_ok, i_enable_pin, i_overvolt, i_undervolt,
                             i_thermal_timer_pin, i_drain_high, i_output_above_ref,
                             i_gate_a_high, i_gate_b_high, i_limit_a, i_load_charged,
                             i_load_good_in, i_aux_fault_pin};
    reg  [NIN-1:0] meta_r;
    reg  [NIN-1:0] sync_r;
    reg      [2:0] fast_meta_r;
    reg      [2:0] fast_sync_r;
    always @(posedge i_sys_clk) begin
        meta_r      <= raw_in;
        sync_r      <= meta_r;
        fast_meta_r <= {i_limit_b, i_fast_b, i_fast_a};
        fast_sync_r <= fast_meta_r;
    end
    wire s_supply = sync_r[12];
    wire s_en     = sync_r[11];
    wire s_ov     = sync_r[10];
    wire s_uv     = sync_r[9];
    wire s_tmr    = sync_r[8];
    wire s_drain  = sync_r[7];
    wire s_outok  = sync_r[6];
    wire s_ga     = sync_r[5];
    wire s_gb     = sync_r[4];
    wire s_lima   = sync_r[3];
    wire s_charge = sync_r[2];
    wire s_gin    = sync_r[1];
    wire s_aux    = sync_r[0];

    // ==================================================================
    // Registers.
    reg [7:0] primary_r;
    reg [7:0] secondary_r;
    reg [7:0] third_r;
    reg [7:0] good_pin_r;
    reg [7:0] restart_r;
    reg [7:0] fault_log_r;
    reg [7:0] fault_set;
    reg       restart_done;
    reg       cmd_on_r;
    reg       good_r;
    reg       dbc_done_r;

    wire [1:0] mode   = secondary_r[`HSG_SC_MODE_LO+1:`HSG_SC_MODE_LO];
    wire       staged = (mode != `HSG_MODE_PARALLEL) && (mode != `HSG_MODE_SINGLE);

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            primary_r   <= `HSG_RST_PRIMARY;
            secondary_r <= `HSG_RST_SECONDARY;
            third_r     <= `HSG_RST_THIRD;
            good_pin_r  <= `HSG_RST_GOOD_PIN;
            restart_r   <= `HSG_RST_RESTART;
            fault_log_r <= 8'h00;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `HSG_OFS_PRIMARY_CONTROL:   primary_r   <= i_reg_wdata;
                    `HSG_OFS_SECONDARY_CONTROL: secondary_r <= i_reg_wdata;
                    `HSG_OFS_THIRD_CONFIG:      third_r     <= i_reg_wdata;
                    `HSG_OFS_GOOD_PIN_CONFIG:   good_pin_r  <= i_reg_wdata;
                    `HSG_OFS_RESTART_CONTROL:   restart_r   <= i_reg_wdata;
                    default: ;
                endcase
            end
            if (restart_done) begin
                restart_r[`HSG_RC_REQUEST] <= 1'b0;
            end
            // Written zeros clear fault bits; a new event in the same cycle wins.
            if (i_reg_wr && i_reg_addr == `HSG_OFS_FAULT_LOG) begin
                fault_log_r <= (fault_log_r & i_reg_wdata) | fault_set;
            end else begin
                fault_log_r <= fault_log_r | fault_set;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `HSG_OFS_SYSTEM_STATE:      o_reg_rdata <= {3'h0, o_ramp_enable, o_drive_b,
                                                             o_drive_a, good_r, cmd_on_r};
                `HSG_OFS_FAULT_LOG:         o_reg_rdata <= fault_log_r;
                `HSG_OFS_PRIMARY_CONTROL:   o_reg_rdata <= primary_r;
                `HSG_OFS_SECONDARY_CONTROL: o_reg_rdata <= secondary_r;
                `HSG_OFS_THIRD_CONFIG:      o_reg_rdata <= third_r;
                `HSG_OFS_GOOD_PIN_CONFIG:   o_reg_rdata <= good_pin_r;
                `HSG_OFS_RESTART_CONTROL:   o_reg_rdata <= restart_r;
                default:                    o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==================================================================
    // Millisecond time base shared by every delay.
    reg [31:0] tick_cnt_r;
    wire       tick = (tick_cnt_r == CYC_PER_MS - 1);
    always @(posedge i_sys_clk) begin
        if (!i_rstn || tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // ==================================================================
    // Fault detection.
    wire on_bit     = primary_r[`HSG_PC_ON];
    wire in_ok      = s_supply && !s_en && !s_ov && !s_uv;
    wire gates_ok   = staged ? s_ga : (s_ga || s_gb);
    wire aux_active = third_r[`HSG_TC_AUX_IS_FAULT] &&
                      (s_aux ^ ~third_r[`HSG_TC_AUX_POL]);               // [RULE16]
    wire gin_active = s_gin ^ good_pin_r[`HSG_GP_IN_INV];                 // [RULE11]
    wire wd_enable  = !good_pin_r[`HSG_GP_IN_GPIO];                       // [RULE11]
    wire [7:0] sw_dly_ms = {4'h0, good_pin_r[`HSG_GP_SWDLY_LO+1:`HSG_GP_SWDLY_LO], 2'h0} + 8'h4;

    reg  [7:0] sw_cnt_r;
    wire       sw_bad = cmd_on_r && good_r && (s_drain || !gates_ok);
    always @(posedge i_sys_clk) begin
        if (!i_rstn || !sw_bad) begin
            sw_cnt_r <= 8'h00;                                            // [RULE22]
        end else if (tick && sw_cnt_r != sw_dly_ms) begin
            sw_cnt_r <= sw_cnt_r + 8'h01;
        end
    end
    wire sw_fault = sw_bad && (sw_cnt_r == sw_dly_ms);                    // [RULE15]

    // ==================================================================
    // Power-good chain: 256ms, 256ms, then 512ms watchdog.
    reg [9:0] good_cnt_r;
    reg [1:0] good_stage_r;
    wire par_ok    = (s_ga || s_gb) && (s_ga || s_lima) && (s_gb || fast_sync_r[2]);
    wire good_cond = cmd_on_r && !s_drain && s_outok && (staged ? s_ga :
                     (mode == `HSG_MODE_PARALLEL) ? par_ok : s_ga && s_gb);   // [RULE6]
    wire wd_fault = good_r && wd_enable && good_stage_r == 2'h2 &&
                    good_cnt_r == `HSG_TIME_WATCHDOG_MS && !gin_active;   // [RULE9]

    // ==================================================================
    // Turn-off causes and retry policy.
    wire [7:0] off_fault;
    assign off_fault[`HSG_FL_OV]       = s_ov && cmd_on_r;
    assign off_fault[`HSG_FL_UV]       = s_uv && cmd_on_r;
    assign off_fault[`HSG_FL_OC]       = s_tmr && cmd_on_r;
    assign off_fault[`HSG_FL_SWITCH]   = sw_fault && primary_r[`HSG_PC_SWFAULT_OFF];   // [RULE15]
    assign off_fault[`HSG_FL_WATCHDOG] = wd_fault;
    assign off_fault[`HSG_FL_EXT]      = aux_active && third_r[`HSG_TC_AUX_OFF_EN];    // [RULE16]
    assign off_fault[7:6]              = 2'h0;
    wire restart_req = restart_r[`HSG_RC_REQUEST];
    wire turn_off = !s_supply || s_en || !on_bit || (|off_fault) || restart_req; // [RULE14]
    wire [5:0] retry_en = {secondary_r[5], secondary_r[0], secondary_r[4:1]}; // [RULE18]

    always @* begin
        fault_set = {2'h0, aux_active, wd_fault, sw_fault, off_fault[2:0]};
    end

    // Latched-off faults and the retry / reboot hold-off.
    reg [5:0] latched_r;
    reg [9:0] hold_cnt_r;
    reg       hold_r;
    reg [9:0] hold_len_r;
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            latched_r  <= 6'h00;
            hold_r     <= 1'b0;
            hold_cnt_r <= 10'h000;
            hold_len_r <= 10'h000;
        end else begin
            latched_r <= (latched_r | (off_fault[5:0] & ~retry_en)) &
                         {6{on_bit}};                                     // [RULE18]
            if (turn_off && cmd_on_r && ((|(off_fault[5:0] & retry_en)) || restart_req)) begin
                hold_r     <= 1'b1;
                hold_cnt_r <= 10'h000;
                hold_len_r <= restart_req ? {restart_r[3:0], 6'h00}       // [RULE17]
                                          : `HSG_TIME_RETRY_MS;           // [RULE10]
            end else if (hold_r && tick) begin
                if (hold_cnt_r == hold_len_r) begin
                    hold_r <= 1'b0;
                end else begin
                    hold_cnt_r <= hold_cnt_r + 10'h001;
                end
            end
        end
    end
    always @* begin
        restart_done = restart_req && hold_r;
    end

    // ==================================================================
    // Startup debounce and switch command.
    reg [7:0] dbc_cnt_r;
    wire start_ok = in_ok && !hold_r && (latched_r == 6'h00) && !restart_req;
    always @(posedge i_sys_clk) begin
        if (!i_rstn || !start_ok) begin
            dbc_cnt_r  <= 8'h00;                                          // [RULE21]
            dbc_done_r <= 1'b0;
        end else if (tick && !dbc_done_r) begin
            if (dbc_cnt_r == `HSG_TIME_DEBOUNCE_MS - 1) begin
                dbc_done_r <= 1'b1;
            end
            dbc_cnt_r <= dbc_cnt_r + 8'h01;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rstn || turn_off) begin
            cmd_on_r <= 1'b0;                                             // [RULE14]
        end else if (dbc_done_r && on_bit && start_ok) begin
            cmd_on_r <= 1'b1;                                             // [RULE21]
        end
    end

    // ==================================================================
    // Power good latch and delay chain.
    wire good_clear = primary_r[`HSG_PC_GOOD_CLEAR] ? !s_outok
                    : (turn_off && !(s_ov && on_bit && s_supply && !s_en &&
                       !restart_req && (off_fault[5:1] == 5'h00)));        // [RULE12]
    always @(posedge i_sys_clk) begin
        if (!i_rstn || good_clear) begin
            good_r       <= 1'b0;                                         // [RULE13]
            good_stage_r <= 2'h0;
            good_cnt_r   <= 10'h000;
        end else if (!good_r) begin
            good_r <= good_cond;                                          // [RULE7]
        end else if (tick) begin
            if (good_stage_r != 2'h2 && good_cnt_r == `HSG_TIME_GOOD_MS - 1) begin
                good_stage_r <= good_stage_r + 2'h1;                      // [RULE8]
                good_cnt_r   <= 10'h000;
            end else if (good_cnt_r != `HSG_TIME_WATCHDOG_MS) begin
                good_cnt_r <= good_cnt_r + 10'h001;
            end
        end
    end

    // ==================================================================
    // Gate drives, ramp and current-limit settings.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_drive_a          <= 1'b0;
            o_drive_b          <= 1'b0;
            o_fast_pull_a      <= 1'b0;
            o_fast_pull_b      <= 1'b0;
            o_ramp_enable      <= 1'b0;
            o_ramp_discharge   <= 1'b1;
            o_slew_mode_select <= 1'b0;
            o_limit_mv         <= 5'h0F;
            o_foldback_sel     <= 2'h0;
            o_load_good_out_a  <= 1'b0;
            o_load_good_out_b  <= 1'b0;
        end else begin
            o_drive_a <= cmd_on_r;                                        // [RULE5]
            o_drive_b <= cmd_on_r && (!staged || s_charge) &&
                         (staged ? (o_drive_a || !o_drive_b) : 1'b1);     // [RULE19]
            o_fast_pull_a <= fast_sync_r[0];                              // [RULE20]
            o_fast_pull_b <= fast_sync_r[1];
            o_slew_mode_select <= primary_r[`HSG_PC_SLEW_MODE];           // [RULE1]
            o_ramp_enable    <= primary_r[`HSG_PC_SLEW_MODE] && cmd_on_r && !good_r; // [RULE2]
            o_ramp_discharge <= !(primary_r[`HSG_PC_SLEW_MODE] && cmd_on_r && !good_r);
            o_limit_mv     <= 5'h0F + {1'b0, third_r[`HSG_TC_ILIM_LO+3:`HSG_TC_ILIM_LO]}; // [RULE3]
            if (!cmd_on_r) begin
                o_foldback_sel <= good_pin_r[`HSG_GP_FOLD_LO+1:`HSG_GP_FOLD_LO];  // [RULE4]
            end
            o_load_good_out_a <= (good_r && good_stage_r != 2'h0) ^
                                 good_pin_r[`HSG_GP_OUTA_INV];            // [RULE7]
            o_load_good_out_b <= (good_r && good_stage_r == 2'h2) ^
                                 good_pin_r[`HSG_GP_OUTB_INV];            // [RULE8]
        end
    end

endmodule

//--- verif/hsg_far_model.sv
// Far-side model of the two switches and the load monitor.
`timescale 1ns/1ps
module hsg_far_model (
    input  wire i_sys_clk,
    input  wire i_drive_a,
    input  wire i_drive_b,
    input  wire i_load_good_out_b,
    input  wire i_monitor_en,
    output wire o_gate_a_high,
    output wire o_gate_b_high,
    output wire o_drain_high,
    output wire o_load_good_in
);
    reg [4:0] ramp_a_r;
    reg [4:0] ramp_b_r;
    // Gates take a few dozen cycles to charge and drop at once when released.
    always @(posedge i_sys_clk) begin
        ramp_a_r <= !i_drive_a ? 5'h00 : (ramp_a_r == 5'h1F) ? ramp_a_r : ramp_a_r + 5'h01;
        ramp_b_r <= !i_drive_b ? 5'h00 : (ramp_b_r == 5'h1F) ? ramp_b_r : ramp_b_r + 5'h01;
    end
    assign o_gate_a_high = (ramp_a_r == 5'h1F);
    assign o_gate_b_high = (ramp_b_r == 5'h1F);
    // The drain stays high until the first switch is fully on.
    assign o_drain_high = !o_gate_a_high;
    // The monitor confirms the load once the second load has been released.
    assign o_load_good_in = i_monitor_en && i_load_good_out_b;
endmodule

//--- verif/hsg_checker_properties.sv
// Concurrent checks on the gate sequencer ports.
`timescale 1ns/1ps
module hsg_checker #(
    parameter CYC_PER_MS = 10
) (
    input wire       i_sys_clk, i_rstn, i_reg_wr,
    input wire [7:0] i_reg_addr, i_reg_wdata,
    input wire       i_supply_ok, i_enable_pin, i_fast_a,
    input wire       o_drive_a, o_drive_b, o_fast_pull_a, o_ramp_enable, o_ramp_discharge,
    input wire       o_slew_mode_select, o_load_good_out_a, o_load_good_out_b,
    input wire [4:0] o_limit_mv
);
    localparam GOOD_CYC = 256 * CYC_PER_MS;
    reg [1:0]  mode_r;
    reg        inv_r;
    reg        slew_r;
    reg [31:0] cnt_a_r;
    wire       wr_pc = i_reg_wr && (i_reg_addr == 8'h0A);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    // Shadows of written mode and slew bits; inv_r sticks once either good output is written inverted.
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            mode_r  <= 2'h0;
            inv_r   <= 1'b0;
            slew_r  <= 1'b0;
            cnt_a_r <= 32'h0;
        end else begin
            if (i_reg_wr && (i_reg_addr == 8'h0B))
                mode_r <= i_reg_wdata[7:6];
            if (i_reg_wr && (i_reg_addr == 8'h10) && (i_reg_wdata[1:0] != 2'h0))
                inv_r <= 1'b1;
            if (wr_pc)
                slew_r <= i_reg_wdata[1];
            cnt_a_r <= o_load_good_out_a ? cnt_a_r + 32'h1 : 32'h0;
        end
    end
    a_limit_range: assert property ((o_limit_mv >= 5'h0F) && (o_limit_mv <= 5'h1E))
        else $error("limit setting out of range");
    a_fast_pull: assert property (i_fast_a [*3] |-> ##[0:2] o_fast_pull_a)
        else $error("fast limit gave no strong pulldown");
    a_drives_pair: assert property ((mode_r == 2'h0 || mode_r == 2'h3) |-> o_drive_a == o_drive_b)
        else $error("drives differ in parallel or single mode");
    a_ramp_discharge: assert property ($fell(o_drive_a) |-> ##[0:2] o_ramp_discharge)
        else $error("ramp not discharged at turn-off");
    a_ramp_slew_only: assert property (o_ramp_enable |-> o_slew_mode_select)
        else $error("ramp active outside slew mode");
    a_slew_follows: assert property (wr_pc |=> ##[0:2] (o_slew_mode_select == slew_r))
        else $error("slew select does not follow its bit");
    a_enable_off: assert property (i_enable_pin [*3] |-> ##[0:2] (!o_drive_a && !o_drive_b))
        else $error("drives on while disabled");
    a_supply_off: assert property (!i_supply_ok [*3] |-> ##[0:2] !o_drive_a)
        else $error("drives on without supply");
    a_good_b_time: assert property ($rose(o_load_good_out_b) && !inv_r |->
        (cnt_a_r >= GOOD_CYC - 3) && (cnt_a_r <= GOOD_CYC + 3))
        else $error("second good output off its delay");
    a_good_b_after_a: assert property (o_load_good_out_b && !inv_r |-> o_load_good_out_a)
        else $error("second good output before the first");
    c_good_b: cover property ($rose(o_load_good_out_b));
    c_drive_off: cover property ($fell(o_drive_a));
    c_fast_pull: cover property ($rose(o_fast_pull_a));
endmodule
bind hsg_gate_sequencer hsg_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.*);

//--- verif/tb.sv
// Self-checking bench for the gate sequencer with its far-side model.
`timescale 1ns/1ps
module tb;
    localparam LIMIT = 80000;
    reg          sys_clk, rstn, reg_wr, reg_rd, supply_ok, fast_a, monitor_en;
    reg  [7:0]   reg_addr, reg_wdata, v;
    reg  [3:0]   cause;
    wire [7:0]   reg_rdata;
    wire         gate_a_high, gate_b_high, drain_high, good_in, drive_a, drive_b;
    wire         pull_a, pull_b, ramp_en, ramp_dis, slew, good_a, good_b;
    wire [4:0]   limit_mv;
    wire [1:0]   fold;
    integer      n, i, errors, total_checks, cycles;
    logic [15:0] rows [8] = '{16'h0000, 16'h0400, 16'h0A09, 16'h0B00,
                              16'h0F01, 16'h1000, 16'hA204, 16'h5500};
    hsg_gate_sequencer #(.CYC_PER_MS(10)) u_dut (
        .i_sys_clk(sys_clk), .i_rstn(rstn), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .i_supply_ok(supply_ok), .i_enable_pin(cause[0]), .i_overvolt(cause[1]),
        .i_undervolt(cause[2]), .i_thermal_timer_pin(cause[3]), .i_drain_high(drain_high),
        .i_output_above_ref(!drain_high), .i_gate_a_high(gate_a_high),
        .i_gate_b_high(gate_b_high), .i_limit_a(1'b0), .i_limit_b(1'b0), .i_fast_a(fast_a),
        .i_fast_b(1'b0), .i_load_charged(!drain_high), .i_load_good_in(good_in),
        .i_aux_fault_pin(1'b0), .o_drive_a(drive_a), .o_drive_b(drive_b),
        .o_fast_pull_a(pull_a), .o_fast_pull_b(pull_b), .o_ramp_enable(ramp_en),
        .o_ramp_discharge(ramp_dis), .o_slew_mode_select(slew), .o_limit_mv(limit_mv),
        .o_foldback_sel(fold), .o_load_good_out_a(good_a), .o_load_good_out_b(good_b));
    hsg_far_model u_far (
        .i_sys_clk(sys_clk), .i_drive_a(drive_a), .i_drive_b(drive_b),
        .i_load_good_out_b(good_b), .i_monitor_en(monitor_en), .o_gate_a_high(gate_a_high),
        .o_gate_b_high(gate_b_high), .o_drain_high(drain_high), .o_load_good_in(good_in));
    task check(input [7:0] seen, input [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    task rd(input [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask
    function logic pick(input integer s);
        pick = (s == 0) ? drive_a : (s == 1) ? good_a : good_b;
    endfunction
    // Waits at falling edges until the chosen output reaches val, counting cycles.
    task wait_sig(input integer s, input logic val, input integer lim);
        n = 0;
        while (pick(s) !== val && n < lim) begin
            @(negedge sys_clk);
            n = n + 1;
        end
    endtask
    task give_verdict;
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            errors = errors + 1;
            give_verdict;
        end
    end
    initial begin
        {rstn, reg_wr, reg_rd, supply_ok, fast_a, monitor_en} = 6'h00;
        {reg_addr, reg_wdata, cause} = 20'h00000;
        {errors, total_checks, cycles} = 96'h0;
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(rows[i][15:8]);
            check(v, rows[i][7:0]);
        end
        for (i = 0; i < 16; i++) begin
            wr(8'h0F, {i[3:0], 4'h1});
            repeat (3) @(negedge sys_clk);
            check({3'h0, limit_mv}, 8'h0F + i[7:0]);
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h10, {2'h0, i[1:0], 4'h0});
            repeat (3) @(negedge sys_clk);
            check({6'h0, fold}, {6'h0, i[1:0]});
        end
        wr(8'h0A, 8'h0B);
        repeat (3) @(negedge sys_clk);
        check({7'h0, slew}, 8'h01);
        supply_ok = 1'b1;
        monitor_en = 1'b1;
        repeat (1200) @(negedge sys_clk);
        check({7'h0, drive_a}, 8'h00);
        wait_sig(0, 1'b1, 300);
        check({6'h0, drive_a, drive_b}, 8'h03);
        repeat (5) @(negedge sys_clk);
        check({7'h0, ramp_en}, 8'h01);
        wait_sig(1, 1'b1, 3000);
        check({7'h0, (n >= 2560) && (n <= 2640)}, 8'h01);
        rd(8'h00);
        check({7'h0, v[1]}, 8'h01);
        check({6'h0, ramp_en, ramp_dis}, 8'h01);
        wait_sig(2, 1'b1, 3000);
        check({7'h0, (n >= 2556) && (n <= 2564)}, 8'h01);
        repeat (5300) @(negedge sys_clk);
        rd(8'h04);
        check({7'h0, drive_a, v[4]}, 8'h02);
        fast_a = 1'b1;
        repeat (5) @(negedge sys_clk);
        check({6'h0, pull_a, pull_b}, 8'h02);
        fast_a = 1'b0;
        repeat (5) @(negedge sys_clk);
        check({7'h0, pull_a}, 8'h00);
        monitor_en = 1'b0;
        wr(8'h0B, 8'h01);
        wr(8'hA2, 8'h81);
        repeat (5) @(negedge sys_clk);
        check({6'h0, drive_a, good_a}, 8'h00);
        wait_sig(0, 1'b1, 3000);
        check({7'h0, drive_a && (n >= 635)}, 8'h01);
        wait_sig(2, 1'b1, 6000);
        wait_sig(0, 1'b0, 5400);
        check({7'h0, (n >= 5116) && (n <= 5130)}, 8'h01);
        rd(8'h04);
        check({7'h0, v[4]}, 8'h01);
        wait_sig(0, 1'b1, 3000);
        check({7'h0, drive_a && (n >= 1275)}, 8'h01);
        monitor_en = 1'b1;
        wr(8'h0A, 8'h09);
        for (i = 0; i < 4; i++) begin
            wait_sig(1, 1'b1, 3000);
            cause[i] = 1'b1;
            repeat (6) @(negedge sys_clk);
            check({6'h0, drive_a, drive_b}, 8'h00);
            check({7'h0, good_a}, {7'h0, i == 1});
            rd(8'h00);
            check({7'h0, v[0]}, 8'h00);
            cause[i] = 1'b0;
            repeat (1400) @(negedge sys_clk);
            check({7'h0, drive_a}, {7'h0, i == 0});
            wr(8'h0A, 8'h08);
            wr(8'h0A, 8'h09);
            wait_sig(0, 1'b1, 3000);
        end
        wr(8'h0A, 8'h08);
        wr(8'h0B, 8'h40);
        wr(8'h0A, 8'h09);
        wait_sig(0, 1'b1, 3000);
        check({6'h0, drive_a, drive_b}, 8'h02);
        repeat (10) @(negedge sys_clk);
        wr(8'h10, 8'h03);
        repeat (4) @(negedge sys_clk);
        check({6'h0, good_a, good_b}, 8'h03);
        give_verdict;
    end
endmodule
